// *** rtl/ikr_regs.vh ***
// register map, field positions and reset values of the interrupt and key return block
`ifndef IKR_REGS_VH
`define IKR_REGS_VH
// ----------------------------------------
// word offsets (byte addresses)
// ----------------------------------------
`define IKR_OFS_REQ_FLAG   8'h00
`define IKR_OFS_MASK       8'h04
`define IKR_OFS_PRIORITY   8'h08
`define IKR_OFS_RISE_EN    8'h0c
`define IKR_OFS_FALL_EN    8'h10
`define IKR_OFS_KEY_EN     8'h14
`define IKR_OFS_PULLUP     8'h18
`define IKR_OFS_PORT_MODE  8'h1c
`define IKR_OFS_CPU_CTRL   8'h20
`define IKR_OFS_KEY_PINS   8'h24
`define IKR_OFS_INT_STAT   8'h28
`define IKR_OFS_INT_MASK   8'h2c
// ----------------------------------------
// request flag bits (upper half layout)
// ----------------------------------------
`define IKR_FLAG_EXT0      0
`define IKR_FLAG_EXT1      1
`define IKR_FLAG_EXT2      2
`define IKR_FLAG_EXT3      3
`define IKR_FLAG_KEY       4
`define IKR_FLAG_USED      8'h1f
// ----------------------------------------
// reset values
// ----------------------------------------
`define IKR_RST_MASK       8'hdf
`define IKR_RST_PRIORITY   8'hff
`define IKR_RST_ZERO       8'h00
`define IKR_RST_PORT_MODE  4'hf
// cpu control bits
`define IKR_CTRL_GIE       0
// interrupt status events
`define IKR_EV_REQ         0
`define IKR_EV_BREAK       1
`define IKR_EV_SPUR        2
`endif

// *** rtl/ikr_edge_det.v ***
// per-pin synchroniser and edge detector with separate rise and fall enables
`timescale 1ns/100ps
`default_nettype none
module ikr_edge_det (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire pin,
  input wire rise_en,
  input wire fall_en,
  output wire level,
  output wire hit
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;
  always @(posedge mclk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign level = sync_reg;
  // only enabled directions are seen, so a disabled pin never raises a request
  assign hit = ce & ((rise_en & sync_reg & ~last_reg) | (fall_en & ~sync_reg & last_reg));
endmodule // ikr_edge_det
`default_nettype wire

// *** rtl/ikr_ctrl.v ***
// interrupt and key return control with wishbone register access
// How it works
// - clear edge enables before port mode switch (not enforced here: an edge seen in port mode is reported as spurious)
// - taking break clears global interrupt enable
// - break holds off acknowledgement
// - key enable change may set key flag
// - key inputs not enabled stay ordinary ports
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ikr_regs.vh"
module ikr_ctrl (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [3:0] ext_pin,
  input wire [7:0] key_pin,
  input wire brk_exec,
  input wire int_ack,
  input wire int_ret,
  output wire irq_req,
  output wire [2:0] irq_src,
  output wire irq_hi_prio,
  output wire [7:0] port7_pullup_bits,
  output wire [7:0] key_port_in,
  output wire [3:0] ext_port_in,
  output wire irq
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] request_flag_reg1_upper_reg;
  reg [7:0] mask_reg1_upper_reg;
  reg [7:0] priority_reg1_upper_reg;
  reg [7:0] rising_edge_enable_reg;
  reg [7:0] falling_edge_enable_reg;
  reg [7:0] key_return_enable_reg;
  reg [7:0] port7_pullup_reg;
  reg [3:0] port_mode_reg;
  reg global_interrupt_enable_reg;
  reg [2:0] int_stat_reg;
  reg [2:0] int_mask_reg;
  reg [7:0] key_last_reg;
  reg [7:0] key_meta_reg;
  reg [7:0] key_sync_reg;
  reg [7:0] key_en_prev_reg;

  wire [3:0] ext_hit;
  wire [3:0] ext_lvl;
  wire wr_stb;
  wire rd_stb;
  wire key_hit;
  wire spur;
  wire [7:0] pend;
  wire [7:0] flag_set;
  wire [3:0] ext_req;
  reg [7:0] request_flag_reg1_upper_next;
  reg [2:0] int_stat_next;

  // ----------------------------------------
  // external pins
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ext
      ikr_edge_det u_det (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .pin(ext_pin[gi]),
        .rise_en(rising_edge_enable_reg[gi]),
        .fall_en(falling_edge_enable_reg[gi]),
        .level(ext_lvl[gi]),
        .hit(ext_hit[gi])
      );
    end
  endgenerate
  assign ext_port_in = ext_lvl;
  // an enable left on across a mode switch is reported, since the edge may be false
  // detection runs in both modes; port mode keeps the edge out of the flags, not out of the spurious status
  assign ext_req = ext_hit & ~port_mode_reg;
  assign spur = |(ext_hit & port_mode_reg);

  // ----------------------------------------
  // key return inputs
  // ----------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      key_meta_reg <= `IKR_RST_ZERO;
      key_sync_reg <= `IKR_RST_ZERO;
      key_last_reg <= `IKR_RST_ZERO;
      key_en_prev_reg <= `IKR_RST_ZERO;
    end else if (ce) begin
      key_meta_reg <= key_pin;
      key_sync_reg <= key_meta_reg;
      key_last_reg <= key_sync_reg;
      key_en_prev_reg <= key_return_enable_reg;
    end
  end
  // falling edge on enabled inputs; a newly enabled low pin also counts
  assign key_hit = |(key_return_enable_reg & ((~key_sync_reg & key_last_reg)
                   | (~key_sync_reg & ~key_en_prev_reg)));
  assign key_port_in = key_sync_reg;
  assign port7_pullup_bits = port7_pullup_reg;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  function [31:0] ikr_rd;
    input [7:0] a;
    begin
      case (a)
        `IKR_OFS_REQ_FLAG: ikr_rd = {24'h000000, request_flag_reg1_upper_reg};
        `IKR_OFS_MASK: ikr_rd = {24'h000000, mask_reg1_upper_reg};
        `IKR_OFS_PRIORITY: ikr_rd = {24'h000000, priority_reg1_upper_reg};
        `IKR_OFS_RISE_EN: ikr_rd = {24'h000000, rising_edge_enable_reg};
        `IKR_OFS_FALL_EN: ikr_rd = {24'h000000, falling_edge_enable_reg};
        `IKR_OFS_KEY_EN: ikr_rd = {24'h000000, key_return_enable_reg};
        `IKR_OFS_PULLUP: ikr_rd = {24'h000000, port7_pullup_reg};
        `IKR_OFS_PORT_MODE: ikr_rd = {28'h0000000, port_mode_reg};
        `IKR_OFS_CPU_CTRL: ikr_rd = {31'h00000000, global_interrupt_enable_reg};
        `IKR_OFS_KEY_PINS: ikr_rd = {20'h00000, ext_lvl, key_sync_reg};
        `IKR_OFS_INT_STAT: ikr_rd = {29'h00000000, int_stat_reg};
        `IKR_OFS_INT_MASK: ikr_rd = {29'h00000000, int_mask_reg};
        default: ikr_rd = 32'h00000000;
      endcase
    end
  endfunction

  // one wait state: ack rises the cycle after the request, and never twice in a row
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~wb_ack_o & ce;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce;

  // ----------------------------------------
  // request, priority and acknowledge
  // ----------------------------------------
  assign flag_set = {3'b000, key_hit, ext_req};
  assign pend = request_flag_reg1_upper_reg & ~mask_reg1_upper_reg & `IKR_FLAG_USED;
  // break holds off acknowledge; the enable flag and brk_exec both gate requests
  assign irq_req = global_interrupt_enable_reg & (|pend) & ~brk_exec;
  function [2:0] ikr_pick;
    input [7:0] p;
    input [7:0] pr;
    integer k;
    reg found;
    begin
      ikr_pick = 3'h0;
      found = 1'b0;
      // high priority (bit clear) wins, then the lowest index
      for (k = 4; k >= 0; k = k - 1)
        if (p[k] & ~pr[k]) begin
          ikr_pick = k[2:0];
          found = 1'b1;
        end
      if (!found)
        for (k = 4; k >= 0; k = k - 1)
          if (p[k])
            ikr_pick = k[2:0];
    end
  endfunction
  assign irq_src = ikr_pick(pend, priority_reg1_upper_reg);
  assign irq_hi_prio = ~priority_reg1_upper_reg[irq_src];
  assign irq = |(int_stat_reg & int_mask_reg);

  // per-bit update: a write replaces the flags, hardware set wins
  always @* begin
    request_flag_reg1_upper_next = request_flag_reg1_upper_reg;
    if (wr_stb && wb_adr_i == `IKR_OFS_REQ_FLAG)
      request_flag_reg1_upper_next = wb_dat_i[7:0] & `IKR_FLAG_USED;
    if (int_ack && irq_req)
      request_flag_reg1_upper_next[irq_src] = 1'b0;
    request_flag_reg1_upper_next = request_flag_reg1_upper_next | flag_set;
    int_stat_next = int_stat_reg;
    if (wr_stb && wb_adr_i == `IKR_OFS_INT_STAT)
      int_stat_next = int_stat_reg & ~wb_dat_i[2:0];
    int_stat_next = int_stat_next | {spur, brk_exec, |flag_set};
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      request_flag_reg1_upper_reg <= `IKR_RST_ZERO;
      mask_reg1_upper_reg <= `IKR_RST_MASK;
      priority_reg1_upper_reg <= `IKR_RST_PRIORITY;
      rising_edge_enable_reg <= `IKR_RST_ZERO;
      falling_edge_enable_reg <= `IKR_RST_ZERO;
      key_return_enable_reg <= `IKR_RST_ZERO;
      port7_pullup_reg <= `IKR_RST_ZERO;
      port_mode_reg <= `IKR_RST_PORT_MODE;
      global_interrupt_enable_reg <= 1'b0;
      int_stat_reg <= 3'h0;
      int_mask_reg <= 3'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= rd_stb;
      if (rd_stb)
        wb_dat_o <= ikr_rd(wb_adr_i);
      request_flag_reg1_upper_reg <= request_flag_reg1_upper_next;
      if (wr_stb) begin
        case (wb_adr_i)
          `IKR_OFS_MASK: mask_reg1_upper_reg <= wb_dat_i[7:0];
          `IKR_OFS_PRIORITY: priority_reg1_upper_reg <= wb_dat_i[7:0];
          `IKR_OFS_RISE_EN: rising_edge_enable_reg <= wb_dat_i[7:0];
          `IKR_OFS_FALL_EN: falling_edge_enable_reg <= wb_dat_i[7:0];
          `IKR_OFS_KEY_EN: key_return_enable_reg <= wb_dat_i[7:0];
          `IKR_OFS_PULLUP: port7_pullup_reg <= wb_dat_i[7:0];
          `IKR_OFS_PORT_MODE: port_mode_reg <= wb_dat_i[3:0];
          `IKR_OFS_INT_MASK: int_mask_reg <= wb_dat_i[2:0];
          default: ;
        endcase
      end
      // cpu side: break clears enable, acknowledge clears it, return restores it
      if (brk_exec || (int_ack && irq_req))
        global_interrupt_enable_reg <= 1'b0;
      else if (int_ret)
        global_interrupt_enable_reg <= 1'b1;
      else if (wr_stb && wb_adr_i == `IKR_OFS_CPU_CTRL)
        global_interrupt_enable_reg <= wb_dat_i[`IKR_CTRL_GIE];
      int_stat_reg <= int_stat_next;
    end
  end
endmodule // ikr_ctrl
`default_nettype wire

// *** verif/ikr_chk.sv ***
// assertion checker on the ports of the interrupt and key return block
`timescale 1ns/100ps
`default_nettype none
module ikr_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic brk_exec,
  input wire logic int_ack,
  input wire logic int_ret,
  input wire logic irq_req,
  input wire logic irq,
  input wire logic [2:0] irq_src,
  input wire logic [7:0] key_pin,
  input wire logic [7:0] key_port_in,
  input wire logic [7:0] port7_pullup_bits
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic req = wb_cyc_i && wb_stb_i && ce;
  chk_ack_next: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  chk_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_brk_block: assert property (brk_exec |-> !irq_req)
    else $error("request offered during break");
  chk_brk_gie: assert property (brk_exec && ce && !int_ret && !req |=> !irq_req)
    else $error("break left interrupts enabled");
  chk_ack_gie: assert property (int_ack && irq_req && ce && !int_ret && !req |=> !irq_req)
    else $error("request still raised after acknowledge");
  chk_key_sync: assert property ($past(ce) && $past(ce, 2) && !$past(rst) && !$past(rst, 2)
    |-> key_port_in == $past(key_pin, 2))
    else $error("key port level wrong");
  chk_pullup_hold: assert property (!req |=> $stable(port7_pullup_bits))
    else $error("pull-ups changed without write");
  chk_src_range: assert property (irq_req |-> irq_src <= 3'h4)
    else $error("request source out of range");
  chk_rst_quiet: assert property (disable iff (1'b0) rst |=> !wb_ack_o && !irq_req && !irq)
    else $error("outputs active after reset");
  cover property (brk_exec);
  cover property (int_ack && irq_req);
  cover property (irq);
endmodule // ikr_chk
bind ikr_ctrl ikr_chk u_chk (.mclk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .brk_exec,
  .int_ack, .int_ret, .irq_req, .irq, .irq_src, .key_pin, .key_port_in, .port7_pullup_bits);
`default_nettype wire

// *** verif/ikr_cpu_model.sv ***
// cpu core model that acknowledges pending maskable requests
`timescale 1ns/100ps
`default_nettype none
module ikr_cpu_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic auto_ack,
  output logic int_ack
);
  // one-cycle acknowledge; never leaves a break through the maskable return
  always @(posedge mclk) begin
    int_ack <= !rst && auto_ack && irq_req && !int_ack;
  end
endmodule // ikr_cpu_model
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the interrupt and key return block
`timescale 1ns/100ps
`default_nettype none
`include "ikr_regs.vh"
module tb;
  logic mclk, rst, cyc, stb, we, software_break_instr, auto_ack, ce, iret;
  wire [3:0] ein;
  wire [2:0] src;
  wire hp;
  logic [7:0] adr, key;
  logic [3:0] ext;
  logic [31:0] wdat, rd;
  wire [31:0] dat_o;
  wire [7:0] pu, kin;
  wire ack, req, ia, irq;
  int n_fail = 0;
  int n_tests = 0;
  ikr_ctrl u_dut (.mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .ext_pin(ext), .key_pin(key), .brk_exec(software_break_instr), .int_ack(ia),
    .int_ret(iret), .irq_req(req), .irq_src(src), .irq_hi_prio(hp), .port7_pullup_bits(pu),
    .key_port_in(kin), .ext_port_in(ein), .irq(irq));
  ikr_cpu_model u_cpu (.mclk(mclk), .rst(rst), .irq_req(req), .auto_ack(auto_ack), .int_ack(ia));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // the wait ends on ack, and only the watchdog ends a hung one; a registered ack is seen at the second edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      t++;
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(ack, 32'h1);
    chk(t, 32'h2);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic t_reset;
    rdc(`IKR_OFS_MASK, 32'hdf);
    rdc(`IKR_OFS_PRIORITY, 32'hff);
    rdc(`IKR_OFS_REQ_FLAG, 32'h0);
    rdc(8'h3c, 32'h0);
  endtask
  task automatic t_key;
    wb(1'b1, `IKR_OFS_PULLUP, 32'h01);
    wb(1'b1, `IKR_OFS_KEY_EN, 32'h01);
    chk(pu, 32'h01);
    key <= 8'hfd;
    repeat (6) @(posedge mclk);
    rdc(`IKR_OFS_REQ_FLAG, 32'h0);
    chk(kin, 32'hfd);
    key <= 8'hfc;
    repeat (6) @(posedge mclk);
    rdc(`IKR_OFS_REQ_FLAG, 32'h10);
  endtask
  task automatic t_brk;
    wb(1'b1, `IKR_OFS_MASK, 32'hcf);
    wb(1'b1, `IKR_OFS_CPU_CTRL, 32'h1);
    @(posedge mclk);
    software_break_instr <= 1'b1;
    @(negedge mclk);
    chk(req, 32'h0);
    @(posedge mclk);
    software_break_instr <= 1'b0;
    @(negedge mclk);
    chk(req, 32'h0);
    rdc(`IKR_OFS_CPU_CTRL, 32'h0);
  endtask
  task automatic t_ack;
    wb(1'b1, `IKR_OFS_PORT_MODE, 32'h0);
    wb(1'b1, `IKR_OFS_RISE_EN, 32'h1);
    ext <= 4'h1;
    repeat (6) @(posedge mclk);
    wb(1'b1, `IKR_OFS_REQ_FLAG, 32'h10);
    rdc(`IKR_OFS_REQ_FLAG, 32'h10);
    wb(1'b1, `IKR_OFS_CPU_CTRL, 32'h1);
    chk({hp, src}, 32'h4);
    auto_ack <= 1'b1;
    repeat (4) @(posedge mclk);
    auto_ack <= 1'b0;
    rdc(`IKR_OFS_REQ_FLAG, 32'h0);
    rdc(`IKR_OFS_CPU_CTRL, 32'h0);
    iret <= 1'b1;
    @(posedge mclk);
    iret <= 1'b0;
    rdc(`IKR_OFS_CPU_CTRL, 32'h1);
  endtask
  task automatic t_keychg;
    wb(1'b1, `IKR_OFS_CPU_CTRL, 32'h0);
    wb(1'b1, `IKR_OFS_PULLUP, 32'h03);
    wb(1'b1, `IKR_OFS_KEY_EN, 32'h03);
    rdc(`IKR_OFS_REQ_FLAG, 32'h10);
    wb(1'b1, `IKR_OFS_REQ_FLAG, 32'h0);
    wb(1'b1, `IKR_OFS_CPU_CTRL, 32'h1);
    @(negedge mclk);
    chk(req, 32'h0);
  endtask
  task automatic t_spur;
    wb(1'b1, `IKR_OFS_PORT_MODE, 32'hf);
    ext <= 4'h0;
    repeat (6) @(posedge mclk);
    ext <= 4'h1;
    repeat (6) @(posedge mclk);
    chk(ein, 32'h1);
    wb(1'b1, `IKR_OFS_INT_MASK, 32'h4);
    @(negedge mclk);
    chk(irq, 32'h1);
    wb(1'b1, `IKR_OFS_INT_MASK, 32'h0);
    @(negedge mclk);
    chk(irq, 32'h0);
    wb(1'b1, `IKR_OFS_INT_STAT, 32'h7);
    wb(1'b1, `IKR_OFS_INT_MASK, 32'h4);
    @(negedge mclk);
    chk(irq, 32'h0);
  endtask
  // with the enable low the synchronisers must hold the old pin levels
  task automatic t_ce;
    @(posedge mclk);
    ce <= 1'b0;
    key <= 8'hff;
    repeat (4) @(posedge mclk);
    chk(kin, 32'hfc);
    ce <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(kin, 32'hff);
    rdc(`IKR_OFS_REQ_FLAG, 32'h0);
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    {cyc, stb, we, software_break_instr, auto_ack, iret, ext, adr, wdat} = '0;
    ce = 1'b1;
    key = 8'hff;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_key;
    t_brk;
    t_ack;
    t_keychg;
    t_spur;
    t_ce;
    end_of_test;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    $display("unexpected at %0t: run hung", $time);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
